// [hw/lcd_command_decoder.sv]
/*
 * Command decoder, addressing and display RAM of a dot-matrix LCD
 * controller, with the 16-entry write queue it uses.
 * Assumes 8080-style host pins that are asynchronous to clk, and a scan
 * engine on clk that fetches pixels through the scan port.
 */
// What this block does
// - Display on/off command drives panel enable
// - Start line command loads six-bit line
// - Start line lands on com 0 or 63
// - Page command loads four-bit page, 0-8
// - Page change leaves display state alone
// - Two nibble commands set column 0-131
// - Data access advances column, page untouched
// - Status read returns busy, seg, off, reset
// - Instructions rejected during initialization or with a full queue
// - Status seg and off bits polarity
// - Status reset bit during pin initialization
// - Data write stores, data read returns RAM
// - Segment direction command maps columns
// - Invert command flips pixel sense only
// - All-on forces pixels, beats invert
// - Bias command picks 1/9 or 1/7
// - Read-modify-write stops read increment
// - End restores column saved at entry
// - Soft reset clears line, column, page, scan
// - Scan direction taken from bit 3
// - Power command loads converter, regulator, follower
// - No-operation changes nothing
// - Column locks past last column
// - Reset pin sets documented defaults
`timescale 1ns/10ps

module lcd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule

module lcd_command_decoder
    import lcd_pkg::*;
(
    // Clock and reset pin
    input wire logic clk,
    input wire logic arst_n,
    // Host parallel port
    input wire logic chip_select_n,
    input wire logic register_select,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [7:0] db_in,
    output logic [7:0] db_out,
    output logic db_oe,
    // Panel configuration
    output logic display_on,
    output logic seg_reverse,
    output logic common_scan_reverse,
    output logic pixel_invert,
    output logic all_pixels_on,
    output logic bias_1_7,
    output logic [5:0] start_line,
    output logic rmw_mode,
    // Power circuits
    output logic converter_enable,
    output logic regulator_enable,
    output logic follower_enable,
    // Status
    output logic busy,
    output logic init_busy,
    // Scan engine port
    input wire logic scan_req,
    input wire logic [5:0] scan_com,
    input wire logic [7:0] scan_seg,
    output logic scan_pixel
);
    // Two-stage synchronisers on every host pin
    logic [11:0] pin_meta;
    logic [11:0] pin_sync;
    logic wr_prev;
    logic rd_prev;
    logic cs_n_s;
    logic rs_s;
    logic wr_s;
    logic rd_s;
    logic [7:0] db_s;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta <= 12'h00f;
            pin_sync <= 12'h00f;
            wr_prev <= 1'b1;
            rd_prev <= 1'b1;
        end
        else
        begin
            pin_meta <= {db_in, chip_select_n, register_select, wr_n, rd_n};
            pin_sync <= pin_meta;
            wr_prev <= wr_s;
            rd_prev <= rd_s;
        end
    end

    assign db_s = pin_sync[11:4];
    assign cs_n_s = pin_sync[3];
    assign rs_s = pin_sync[2];
    assign wr_s = pin_sync[1];
    assign rd_s = pin_sync[0];

    logic wr_evt;
    logic rd_evt;
    assign wr_evt = wr_s && !wr_prev && !cs_n_s;
    assign rd_evt = !rd_s && rd_prev && !cs_n_s;

    // Initialization after the reset pin
    lcd_state_type state;
    logic [6:0] init_cnt;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_INIT;
            init_cnt <= '0;
        end
        else
        begin
            case (state)
                ST_INIT:
                begin
                    init_cnt <= init_cnt + 7'h01;
                    if (init_cnt == INIT_LAST)
                    begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    init_cnt <= init_cnt;
                end
                default:
                begin
                    state <= ST_INIT;
                end
            endcase
        end
    end

    assign init_busy = state == ST_INIT;

    // Write queue; a full queue or initialization drops the write
    logic q_in_valid;
    logic q_in_ready;
    logic q_out_valid;
    logic q_out_ready;
    logic [8:0] q_out_data;

    assign q_in_valid = wr_evt && !init_busy;
    // Host reads and the scan engine own the RAM first
    assign q_out_ready = !init_busy && !rd_evt && !scan_req;

    lcd_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(q_in_valid),
        .in_ready(q_in_ready),
        .in_data({rs_s, db_s}),
        .out_valid(q_out_valid),
        .out_ready(q_out_ready),
        .out_data(q_out_data)
    );

    assign busy = init_busy || q_out_valid || !q_in_ready;

    // Command decode
    logic pop;
    logic is_cmd;
    logic is_wdata;
    logic [7:0] cmd;
    assign pop = q_out_valid && q_out_ready;
    assign cmd = q_out_data[7:0];
    assign is_cmd = pop && !q_out_data[8];
    assign is_wdata = pop && q_out_data[8];

    logic dec_display;
    logic dec_seg;
    logic dec_invert;
    logic dec_all_on;
    logic dec_bias;
    logic dec_line;
    logic dec_page;
    logic dec_col_hi;
    logic dec_col_lo;
    logic dec_scan;
    logic dec_power;
    logic dec_rmw;
    logic dec_end;
    logic dec_reset;
    assign dec_display = is_cmd && cmd[7:1] == OP_DISPLAY;
    assign dec_seg = is_cmd && cmd[7:1] == OP_SEG_DIR;
    assign dec_invert = is_cmd && cmd[7:1] == OP_INVERT;
    assign dec_all_on = is_cmd && cmd[7:1] == OP_ALL_ON;
    assign dec_bias = is_cmd && cmd[7:1] == OP_BIAS;
    assign dec_line = is_cmd && cmd[7:6] == OP_START_LINE;
    assign dec_page = is_cmd && cmd[7:4] == OP_PAGE;
    assign dec_col_hi = is_cmd && cmd[7:4] == OP_COL_HI;
    assign dec_col_lo = is_cmd && cmd[7:4] == OP_COL_LO;
    assign dec_scan = is_cmd && cmd[7:4] == OP_SCAN_DIR;
    assign dec_power = is_cmd && cmd[7:3] == OP_POWER;
    assign dec_rmw = is_cmd && cmd == OP_RMW_ENTER;
    assign dec_end = is_cmd && cmd == OP_RMW_END;
    assign dec_reset = is_cmd && cmd == OP_SOFT_RESET;
    // No-operation and undefined bytes match none of these

    // Panel mode flags
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            display_on <= 1'b0;
            seg_reverse <= 1'b0;
            pixel_invert <= 1'b0;
            all_pixels_on <= 1'b0;
            bias_1_7 <= 1'b0;
            converter_enable <= 1'b0;
            regulator_enable <= 1'b0;
            follower_enable <= 1'b0;
        end
        else
        begin
            if (dec_display)
                display_on <= cmd[0];
            if (dec_seg)
                seg_reverse <= cmd[0];
            if (dec_invert)
                pixel_invert <= cmd[0];
            if (dec_all_on)
                all_pixels_on <= cmd[0];
            if (dec_bias)
                bias_1_7 <= cmd[0];
            if (dec_power)
            begin
                converter_enable <= cmd[2];
                regulator_enable <= cmd[1];
                follower_enable <= cmd[0];
            end
        end
    end

    // Start line and scan direction, cleared by soft reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            start_line <= '0;
            common_scan_reverse <= 1'b0;
        end
        else if (dec_reset)
        begin
            start_line <= '0;
            common_scan_reverse <= 1'b0;
        end
        else
        begin
            if (dec_line)
                start_line <= cmd[5:0];
            if (dec_scan)
                common_scan_reverse <= cmd[SCAN_DIR_BIT];
        end
    end

    // Page address; selects data target only
    logic [3:0] page;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            page <= '0;
        else if (dec_reset)
            page <= '0;
        else if (dec_page)
            page <= cmd[3:0];
    end

    // Column address with lock and read-modify-write save
    logic [7:0] column;
    logic [7:0] rmw_saved;
    logic col_step;
    assign col_step = (is_wdata || (rd_evt && rs_s && !rmw_mode))
        && column < COL_LIMIT;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            column <= '0;
            rmw_mode <= 1'b0;
            rmw_saved <= '0;
        end
        else
        begin
            if (dec_reset)
                column <= '0;
            else if (dec_col_hi)
                column <= {cmd[3:0], column[3:0]};
            else if (dec_col_lo)
                column <= {column[7:4], cmd[3:0]};
            else if (dec_end && rmw_mode)
                column <= rmw_saved;
            else if (col_step)
                column <= column + 8'h01;
            if (dec_rmw)
            begin
                rmw_mode <= 1'b1;
                rmw_saved <= column;
            end
            else if (dec_end)
                rmw_mode <= 1'b0;
        end
    end

    // Display RAM: eight full pages and one icon page
    logic [7:0] ram [RAM_WORDS];
    logic [10:0] host_idx;
    logic host_ok;
    assign host_idx = 11'(page) * PAGE_STRIDE + 11'(column);
    assign host_ok = page <= PAGE_ICON && column < COL_LIMIT;

    always_ff @(posedge clk)
    begin
        if (is_wdata && host_ok)
        begin
            if (page == PAGE_ICON)
                ram[host_idx] <= {7'h00, cmd[0]};
            else
                ram[host_idx] <= cmd;
        end
    end

    // Host read answer, held while the read strobe is low
    logic [7:0] status;
    assign status = {busy, !seg_reverse, !display_on, init_busy, 4'h0};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            db_out <= '0;
            db_oe <= 1'b0;
        end
        else
        begin
            if (rd_evt)
                db_out <= rs_s ? (host_ok ? ram[host_idx] : 8'h00) : status;
            db_oe <= !rd_s && !cs_n_s;
        end
    end

    // Scan fetch: common and segment to RAM bit
    logic [5:0] scan_line;
    logic [7:0] scan_col;
    logic [10:0] scan_idx;
    logic scan_bit;
    assign scan_line = start_line
        + (common_scan_reverse ? COM_LAST - scan_com : scan_com);
    assign scan_col = seg_reverse ? SEG_LAST - scan_seg : scan_seg;
    assign scan_idx = 11'(scan_line[5:3]) * PAGE_STRIDE + 11'(scan_col);
    assign scan_bit = scan_col < COL_LIMIT && ram[scan_idx][scan_line[2:0]];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            scan_pixel <= 1'b0;
        else
            scan_pixel <= display_on && (all_pixels_on || (scan_bit ^ pixel_invert));
    end

    // Checks
    property p_display;
        @(posedge clk) disable iff (!arst_n)
        dec_display |=> display_on == $past(cmd[0]);
    endproperty
    a_display: assert property (p_display)
        else $error("display flag wrong");

    property p_line;
        @(posedge clk) disable iff (!arst_n)
        dec_line && !dec_reset |=> start_line == $past(cmd[5:0]);
    endproperty
    a_line: assert property (p_line)
        else $error("start line not loaded");

    property p_page_quiet;
        @(posedge clk) disable iff (!arst_n)
        dec_page |=> $stable(display_on) && $stable(start_line) && page == $past(cmd[3:0]);
    endproperty
    a_page_quiet: assert property (p_page_quiet)
        else $error("page write disturbed display");

    property p_lock;
        @(posedge clk) disable iff (!arst_n)
        column == COL_LIMIT && !is_cmd |=> column == COL_LIMIT;
    endproperty
    a_lock: assert property (p_lock)
        else $error("column moved while locked");

    property p_wstep;
        @(posedge clk) disable iff (!arst_n)
        is_wdata && column < COL_LIMIT |=> column == $past(column) + 8'h01 && $stable(page);
    endproperty
    a_wstep: assert property (p_wstep)
        else $error("column not advanced");

    property p_status;
        @(posedge clk) disable iff (!arst_n)
        rd_evt && !rs_s |=> db_out[3:0] == 4'h0 && db_out[STAT_RESET] == $past(init_busy)
            && db_out[STAT_OFF] == !$past(display_on)
            && db_out[STAT_SEG] == !$past(seg_reverse) && db_out[STAT_BUSY] == $past(busy);
    endproperty
    a_status: assert property (p_status)
        else $error("status byte wrong");

    property p_reject;
        @(posedge clk) disable iff (!arst_n)
        init_busy |-> !q_in_valid && !pop;
    endproperty
    a_reject: assert property (p_reject)
        else $error("instruction taken while busy");

    property p_init;
        @(posedge clk) disable iff (!arst_n)
        $rose(arst_n) |-> init_busy [*8];
    endproperty
    a_init: assert property (p_init)
        else $error("reset flag dropped early");

    sequence s_rmw_in;
        dec_rmw ##1 rmw_mode;
    endsequence
    sequence s_rmw_read;
        rmw_mode && rd_evt && rs_s;
    endsequence
    sequence s_rmw_leave;
        rmw_mode && dec_end;
    endsequence
    property p_rmw_read;
        @(posedge clk) disable iff (!arst_n)
        s_rmw_read |=> $stable(column);
    endproperty
    a_rmw_read: assert property (p_rmw_read)
        else $error("column moved on rmw read");

    property p_rmw_enter;
        @(posedge clk) disable iff (!arst_n)
        s_rmw_in |-> rmw_saved == $past(column);
    endproperty
    a_rmw_enter: assert property (p_rmw_enter)
        else $error("column not saved at rmw entry");

    property p_rmw_end;
        @(posedge clk) disable iff (!arst_n)
        s_rmw_leave |=> column == $past(rmw_saved) && !rmw_mode;
    endproperty
    a_rmw_end: assert property (p_rmw_end)
        else $error("column not restored");

    property p_soft_reset;
        @(posedge clk) disable iff (!arst_n)
        dec_reset |=> column == 8'h00 && page == 4'h0 && start_line == 6'h00
            && !common_scan_reverse && $stable(display_on);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset incomplete");

    property p_nop;
        @(posedge clk) disable iff (!arst_n)
        is_cmd && cmd == OP_NOP && !rd_evt |=> $stable(column) && $stable(page)
            && $stable(display_on) && $stable(rmw_mode);
    endproperty
    a_nop: assert property (p_nop)
        else $error("no-operation changed state");
endmodule

// [hw/lcd_pkg.sv]
/*
 * Constants shared by the LCD command decoder: opcodes, field positions,
 * display geometry and timing.
 * Assumes a single 125 MHz clock domain.
 */
package lcd_pkg;
    // Clock and reset timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_TIME_NS = 1000;
    localparam int INIT_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] INIT_LAST = 7'(INIT_CYCLES - 1);

    // Display geometry
    localparam logic [7:0] COL_LIMIT = 8'h84;
    localparam logic [7:0] SEG_LAST = 8'h83;
    localparam logic [5:0] COM_LAST = 6'h3f;
    localparam logic [3:0] PAGE_ICON = 4'h8;
    localparam logic [10:0] PAGE_STRIDE = 11'h084;
    localparam int RAM_WORDS = 1188;

    // Command opcodes, upper seven bits with a flag in bit 0
    localparam logic [6:0] OP_DISPLAY = 7'h57;
    localparam logic [6:0] OP_SEG_DIR = 7'h50;
    localparam logic [6:0] OP_INVERT = 7'h53;
    localparam logic [6:0] OP_ALL_ON = 7'h52;
    localparam logic [6:0] OP_BIAS = 7'h51;
    // Prefix opcodes
    localparam logic [1:0] OP_START_LINE = 2'h1;
    localparam logic [3:0] OP_PAGE = 4'hb;
    localparam logic [3:0] OP_COL_HI = 4'h1;
    localparam logic [3:0] OP_COL_LO = 4'h0;
    localparam logic [3:0] OP_SCAN_DIR = 4'hc;
    localparam logic [4:0] OP_POWER = 5'h05;
    // Whole-byte opcodes
    localparam logic [7:0] OP_RMW_ENTER = 8'he0;
    localparam logic [7:0] OP_RMW_END = 8'hee;
    localparam logic [7:0] OP_SOFT_RESET = 8'he2;
    localparam logic [7:0] OP_NOP = 8'he3;

    // Field positions
    localparam int SCAN_DIR_BIT = 3;
    localparam int STAT_BUSY = 7;
    localparam int STAT_SEG = 6;
    localparam int STAT_OFF = 5;
    localparam int STAT_RESET = 4;

    // Write queue shape
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [0:0] {ST_INIT, ST_RUN} lcd_state_type;
endpackage

// [tb/lcd_host_model.sv]
/*
 * Host processor model for the 8080-style port of the LCD decoder.
 * Assumes the bench runs its tasks one at a time on a running clk.
 */
`timescale 1ns/10ps
module lcd_host_model (
    // Clock
    input wire logic clk,
    // Port pins
    output logic chip_select_n,
    output logic register_select,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] db_in,
    // Device answer
    input wire logic [7:0] db_out,
    input wire logic busy
);
    initial
    begin
        chip_select_n = 1'b1;
        register_select = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        db_in = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Byte and select held four clocks each side of the rising strobe
    task automatic wr(input logic rs, input logic [7:0] d);
        step(1);
        chip_select_n = 1'b0;
        register_select = rs;
        db_in = d;
        wr_n = 1'b0;
        step(4);
        wr_n = 1'b1;
        step(4);
        chip_select_n = 1'b1;
        // Released bus shows the inverse so stale data cannot pass
        db_in = ~d;
        register_select = ~rs;
    endtask

    task automatic rd(input logic rs, output logic [7:0] d);
        step(1);
        chip_select_n = 1'b0;
        register_select = rs;
        rd_n = 1'b0;
        step(6);
        d = db_out;
        rd_n = 1'b1;
        step(3);
        chip_select_n = 1'b1;
    endtask

    // Bounded wait before any new request
    task automatic idle(output logic ok);
        ok = 1'b0;
        repeat (400)
        begin
            if (busy === 1'b0)
                ok = 1'b1;
            if (ok === 1'b0)
                step(1);
        end
    endtask
endmodule

// [tb/lcd_command_decoder_bench.sv]
/*
 * Self-checking bench for lcd_command_decoder: command table, reset,
 * addressing, read-modify-write, soft reset and scan port.
 * Assumes lcd_host_model drives the host pins.
 */
`timescale 1ns/10ps
module lcd_command_decoder_bench
    import lcd_pkg::*;
;
    typedef struct packed {logic [7:0] cmd; logic [14:0] exp;} lcd_row_type;
    typedef struct packed {logic [7:0] cmd; logic [5:0] com; logic [7:0] seg; logic exp;} lcd_pix_type;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic scan_req = 1'b0;
    logic [5:0] scan_com = 6'h00;
    logic [7:0] scan_seg = 8'h00;
    logic chip_select_n, register_select, wr_n, rd_n, db_oe, busy, init_busy;
    logic display_on, seg_reverse, common_scan_reverse, pixel_invert, all_pixels_on;
    logic bias_1_7, rmw_mode, converter_enable, regulator_enable, follower_enable;
    logic scan_pixel, ok;
    logic [5:0] start_line;
    logic [7:0] db_in, db_out, rv;
    logic [14:0] cfg, e;
    lcd_pix_type p;
    int n_errors = 0;
    int samples_checked = 0;
    lcd_row_type rows [18] = '{'{8'haf, 15'h4000}, '{8'ha1, 15'h6000}, '{8'hc8, 15'h7000},
        '{8'ha7, 15'h7800}, '{8'ha5, 15'h7c00}, '{8'ha3, 15'h7e00}, '{8'h2f, 15'h7fc0},
        '{8'h7f, 15'h7fff}, '{8'he3, 15'h7fff}, '{8'h33, 15'h7fff}, '{8'h2a, 15'h7ebf},
        '{8'hc7, 15'h6ebf}, '{8'hae, 15'h2ebf}, '{8'ha0, 15'h0ebf}, '{8'ha6, 15'h06bf},
        '{8'ha4, 15'h02bf}, '{8'ha2, 15'h00bf}, '{8'h55, 15'h0095}};
    lcd_pix_type pix [8] = '{'{8'h42, 6'h00, 8'h00, 1'b1}, '{8'h33, 6'h04, 8'h00, 1'b0},
        '{8'hc8, 6'h3f, 8'h00, 1'b1}, '{8'he3, 6'h3b, 8'h00, 1'b0},
        '{8'ha1, 6'h3f, 8'h83, 1'b1}, '{8'ha7, 6'h3f, 8'h83, 1'b0},
        '{8'ha5, 6'h3f, 8'h83, 1'b1}, '{8'hae, 6'h3f, 8'h83, 1'b0}};

    assign cfg = {display_on, seg_reverse, common_scan_reverse, pixel_invert, all_pixels_on,
        bias_1_7, converter_enable, regulator_enable, follower_enable, start_line};

    always #4 clk = ~clk;

    lcd_command_decoder dut (.clk, .arst_n, .chip_select_n, .register_select, .wr_n, .rd_n,
        .db_in, .db_out, .db_oe, .display_on, .seg_reverse, .common_scan_reverse,
        .pixel_invert, .all_pixels_on, .bias_1_7, .start_line, .rmw_mode, .converter_enable,
        .regulator_enable, .follower_enable, .busy, .init_busy, .scan_req, .scan_com,
        .scan_seg, .scan_pixel);

    lcd_host_model host (.clk, .chip_select_n, .register_select, .wr_n, .rd_n, .db_in,
        .db_out, .busy);

    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Extra edges so a popped command has landed
    task automatic settle();
        host.idle(ok);
        host.step(2);
        check("idle", 15'(ok), 15'h0001);
    endtask

    task automatic put(input logic rs, input logic [7:0] d);
        settle();
        host.wr(rs, d);
    endtask

    task automatic get(input logic rs, input logic [7:0] exp, input string what);
        settle();
        host.rd(rs, rv);
        check(what, 15'(rv), 15'(exp));
    endtask

    task automatic addr(input logic [3:0] pg, input logic [7:0] c);
        put(1'b0, {OP_PAGE, pg});
        put(1'b0, {OP_COL_HI, c[7:4]});
        put(1'b0, {OP_COL_LO, c[3:0]});
    endtask

    initial
    begin
        repeat (8000) @(posedge clk);
        n_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        wrap_up();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        check("reset cfg", cfg, 15'h0000);
        check("reset busy", 15'({busy, init_busy, db_oe}), 15'h0006);
        arst_n = 1'b1;
        // Write during init must be dropped
        host.wr(1'b0, 8'haf);
        host.rd(1'b0, rv);
        check("init status", 15'(rv), 15'h00f0);
        get(1'b0, 8'h60, "ready status");
        check("dropped", 15'(display_on), 15'h0000);
        foreach (rows[i])
        begin
            e = rows[i].exp;
            put(1'b0, rows[i].cmd);
            get(1'b0, {1'b0, ~e[13], ~e[14], 5'h00}, "status");
            check("cfg a", cfg & 15'h7000, e & 15'h7000);
            check("cfg b", cfg & 15'h0e00, e & 15'h0e00);
            check("cfg c", cfg & 15'h01ff, e & 15'h01ff);
        end
        addr(4'h2, 8'h00);
        put(1'b1, 8'h01);
        addr(4'h2, 8'h82);
        put(1'b1, 8'haa);
        put(1'b1, 8'hbb);
        put(1'b1, 8'hcc);
        addr(4'h3, 8'h82);
        put(1'b1, 8'h5e);
        settle();
        check("page keeps", cfg, 15'h0095);
        addr(4'h2, 8'h82);
        get(1'b1, 8'haa, "data 130");
        get(1'b1, 8'hbb, "data 131");
        get(1'b1, 8'h00, "data 132");
        addr(4'h2, 8'h00);
        get(1'b1, 8'h01, "no wrap");
        addr(4'h3, 8'h82);
        get(1'b1, 8'h5e, "page 3");
        addr(4'h2, 8'h10);
        put(1'b1, 8'h5a);
        put(1'b1, 8'h5b);
        addr(4'h2, 8'h10);
        put(1'b0, OP_RMW_ENTER);
        settle();
        check("rmw on", 15'(rmw_mode), 15'h0001);
        get(1'b1, 8'h5a, "rmw read");
        get(1'b1, 8'h5a, "rmw hold");
        put(1'b1, 8'h77);
        get(1'b1, 8'h5b, "rmw write step");
        put(1'b0, OP_RMW_END);
        get(1'b1, 8'h77, "rmw restore");
        get(1'b1, 8'h5b, "after rmw");
        check("rmw off", 15'(rmw_mode), 15'h0000);
        addr(4'h8, 8'h00);
        put(1'b1, 8'hff);
        addr(4'h9, 8'h00);
        put(1'b1, 8'hff);
        addr(4'h8, 8'h00);
        get(1'b1, 8'h01, "icon page");
        addr(4'h9, 8'h00);
        get(1'b1, 8'h00, "page 9");
        put(1'b0, 8'hc8);
        put(1'b0, 8'haf);
        put(1'b0, OP_SOFT_RESET);
        put(1'b1, 8'h3c);
        settle();
        check("soft reset", cfg, 15'h4080);
        addr(4'h0, 8'h00);
        get(1'b1, 8'h3c, "home write");
        foreach (pix[i])
        begin
            p = pix[i];
            put(1'b0, p.cmd);
            settle();
            scan_req = 1'b1;
            scan_com = p.com;
            scan_seg = p.seg;
            host.step(2);
            check("pixel", 15'(scan_pixel), 15'(p.exp));
            scan_req = 1'b0;
        end
        // Second reset in mid-run, with modes left set by the pixel rows
        arst_n = 1'b0;
        host.step(2);
        check("mid reset cfg", cfg, 15'h0000);
        check("mid reset busy", 15'({busy, init_busy, db_oe}), 15'h0006);
        arst_n = 1'b1;
        host.rd(1'b0, rv);
        check("mid status", 15'(rv), 15'h00f0);
        wrap_up();
    end
endmodule
